//--- cluster_counter.sv
`timescale 1ns/1ns
module cluster_counter #(
  parameter int unsigned N = perf_event_pkg::CLUSTER_WIDTH
) (
  input  wire logic         snoop_valid,
  input  wire logic [N-1:0] snoop_clusters,
  output logic              any_cluster
);

  // Several snoops into one cluster share one bit, so the cluster counts once.
  assign any_cluster = snoop_valid && (|snoop_clusters);

endmodule : cluster_counter

//--- cycle_counter.sv
`timescale 1ns/1ns
module cycle_counter #(
  parameter int unsigned WIDTH = perf_event_pkg::CYCLE_WIDTH
) (
  input  wire logic             clk,
  input  wire logic             nrst,
  input  wire logic             clock_running,
  input  wire logic             count_reset,
  output logic      [WIDTH-1:0] count
);

  logic [WIDTH-1:0] count_reg;
  logic [WIDTH-1:0] count_next;

  // A stopped gated clock must not advance the count, so a held enable freezes it.
  assign count_next = count_reset   ? '0 :
                      clock_running ? count_reg + {{(WIDTH-1){1'b0}}, 1'b1} :
                                      count_reg;
  assign count      = count_reg;

  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      count_reg <= '0;
    end else begin
      count_reg <= count_next;
    end
  end

endmodule : cycle_counter

//--- event_tally.sv
`timescale 1ns/1ns
// Local counters fed by the event pulses; a clear lets each test start from zero.
module event_tally #(
  parameter int N = 15
) (
  input  wire logic         clk,
  input  wire logic         nrst,
  input  wire logic         clr,
  input  wire logic [N-1:0] ev,
  output logic      [15:0]  cnt [N]
);
  always_ff @(posedge clk or negedge nrst) begin
    for (int i = 0; i < N; i++) begin
      if (!nrst || clr) begin
        cnt[i] <= 16'h0;
      end else begin
        cnt[i] <= cnt[i] + 16'(ev[i]);
      end
    end
  end
endmodule : event_tally

//--- home_node_perf_event_gen.sv
`timescale 1ns/1ns
module home_node_perf_event_gen #(
  parameter int unsigned CYCLE_W   = perf_event_pkg::CYCLE_WIDTH,
  parameter int unsigned CLUSTER_W = perf_event_pkg::CLUSTER_WIDTH,
  parameter int unsigned QOS_W     = perf_event_pkg::QOS_WIDTH
) (
  input  wire logic                                clk,
  input  wire logic                                nrst,
  input  wire logic                                global_clock_running,
  input  wire logic                                cycle_count_reset,
  input  wire logic                                miss_rate_slot_granted,
  input  wire logic                                lookup_valid,
  input  wire perf_event_pkg::lookup_kind_t        lookup_kind,
  input  wire logic                                lookup_high_priority,
  input  wire logic                                lookup_hit,
  input  wire logic                                fill_valid,
  input  wire perf_event_pkg::fill_source_t        fill_source,
  input  wire logic                                req_valid,
  input  wire logic                                req_credit_available,
  input  wire logic                                req_static_credit,
  input  wire logic [QOS_W-1:0]                    req_qos,
  input  wire logic                                filter_lookup_valid,
  input  wire perf_event_pkg::lookup_kind_t        filter_lookup_kind,
  input  wire logic                                filter_lookup_hit,
  input  wire logic                                filter_evict_valid,
  input  wire logic                                filter_evict_shared,
  input  wire logic                                snoop_valid,
  input  wire logic                                snoop_broadcast,
  input  wire logic [CLUSTER_W-1:0]                snoop_clusters,
  input  wire logic                                memctl_request,
  input  wire logic                                memctl_retry,
  input  wire logic                                requester_evict_valid,
  input  wire logic                                requester_line_shared,
  input  wire logic                                cluster_single_requester,
  output logic [CYCLE_W-1:0]                       cycle_count,
  output logic                                     retry_ack,
  output logic                                     awaiting_static_credit,
  output logic                                     queue_accept,
  output logic                                     queue_accept_top_qos,
  output logic                                     clear_tracking,
  output logic                                     slc_miss_event,
  output logic                                     slc_access_event,
  output logic                                     slc_fill_event,
  output logic                                     queue_retry_event,
  output logic                                     requests_received_event,
  output logic                                     filter_hit_event,
  output logic                                     filter_eviction_event,
  output logic                                     snoops_issued_event,
  output logic                                     snoop_broadcast_event,
  output logic                                     memctl_retry_event,
  output logic                                     memctl_request_event,
  output logic                                     cluster_snoop_event,
  output logic                                     imprecise_evict_event,
  output logic                                     shared_line_evict_event,
  output logic                                     top_qos_retry_event
);

  // The clock-gating status comes from another power domain; synchronise it.
  logic [perf_event_pkg::SYNC_STAGES-1:0] run_sync_reg;
  logic [CYCLE_W-1:0]                     cycle_raw;
  logic                                   cluster_any;

  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      run_sync_reg <= '0;
    end else begin
      run_sync_reg <= {run_sync_reg[0], global_clock_running};
    end
  end

  cycle_counter #(
    .WIDTH(CYCLE_W)
  ) u_cycle (
    .clk          (clk),
    .nrst         (nrst),
    .clock_running(run_sync_reg[perf_event_pkg::SYNC_STAGES-1]),
    .count_reset  (cycle_count_reset),
    .count        (cycle_raw)
  );

  cluster_counter #(
    .N(CLUSTER_W)
  ) u_cluster (
    .snoop_valid   (snoop_valid),
    .snoop_clusters(snoop_clusters),
    .any_cluster   (cluster_any)
  );

  // Only high-priority first lookups count; tag updates, victim picks and fills are silent.
  wire first_lookup   = lookup_valid && lookup_high_priority &&
                        (lookup_kind == perf_event_pkg::LOOKUP_FIRST);
  // The miss-rate pair is only driven while this node holds one of the slots.
  wire miss_rate_on   = miss_rate_slot_granted;
  wire access_d       = first_lookup && miss_rate_on;
  wire miss_d         = first_lookup && !lookup_hit && miss_rate_on;
  wire fill_d         = fill_valid && (fill_source != perf_event_pkg::FILL_NONE);
  wire no_credit      = req_valid && !req_credit_available;
  wire accept         = req_valid && req_credit_available;
  wire is_top_qos     = req_qos == perf_event_pkg::QOS_TOP;
  wire filter_hit_d   = filter_lookup_valid && filter_lookup_hit &&
                        (filter_lookup_kind == perf_event_pkg::LOOKUP_FIRST);
  wire filter_evict_d = filter_evict_valid;
  wire shared_evict_d = filter_evict_valid && filter_evict_shared;
  wire imprecise_d    = requester_evict_valid && requester_line_shared &&
                        !cluster_single_requester;
  wire clear_d        = requester_evict_valid &&
                        (cluster_single_requester || !requester_line_shared);

  logic wait_reg;
  logic wait_next;

  // A retried request waits until a static credit is granted to it.
  assign wait_next = no_credit ? 1'b1 :
                     req_static_credit ? 1'b0 : wait_reg;

  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      wait_reg <= 1'b0;
    end else begin
      wait_reg <= wait_next;
    end
  end

  // Each output is its own flop, so every output follows its source one cycle later.
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      cycle_count <= '0;
    end else begin
      cycle_count <= cycle_raw;
    end
  end

  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      slc_miss_event <= 1'b0;
    end else begin
      slc_miss_event <= miss_d;
    end
  end

  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      slc_access_event <= 1'b0;
    end else begin
      slc_access_event <= access_d;
    end
  end

  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      slc_fill_event <= 1'b0;
    end else begin
      slc_fill_event <= fill_d;
    end
  end

  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      queue_retry_event <= 1'b0;
    end else begin
      queue_retry_event <= no_credit;
    end
  end

  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      requests_received_event <= 1'b0;
    end else begin
      requests_received_event <= req_valid;
    end
  end

  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      filter_hit_event <= 1'b0;
    end else begin
      filter_hit_event <= filter_hit_d;
    end
  end

  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      filter_eviction_event <= 1'b0;
    end else begin
      filter_eviction_event <= filter_evict_d;
    end
  end

  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      snoops_issued_event <= 1'b0;
    end else begin
      snoops_issued_event <= snoop_valid;
    end
  end

  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      snoop_broadcast_event <= 1'b0;
    end else begin
      snoop_broadcast_event <= snoop_valid && snoop_broadcast;
    end
  end

  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      memctl_retry_event <= 1'b0;
    end else begin
      memctl_retry_event <= memctl_retry;
    end
  end

  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      memctl_request_event <= 1'b0;
    end else begin
      memctl_request_event <= memctl_request;
    end
  end

  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      cluster_snoop_event <= 1'b0;
    end else begin
      cluster_snoop_event <= cluster_any;
    end
  end

  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      imprecise_evict_event <= 1'b0;
    end else begin
      imprecise_evict_event <= imprecise_d;
    end
  end

  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      shared_line_evict_event <= 1'b0;
    end else begin
      shared_line_evict_event <= shared_evict_d;
    end
  end

  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      top_qos_retry_event <= 1'b0;
    end else begin
      top_qos_retry_event <= no_credit && is_top_qos;
    end
  end

  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      retry_ack <= 1'b0;
    end else begin
      retry_ack <= no_credit;
    end
  end

  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      awaiting_static_credit <= 1'b0;
    end else begin
      awaiting_static_credit <= wait_next;
    end
  end

  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      queue_accept <= 1'b0;
    end else begin
      queue_accept <= accept;
    end
  end

  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      queue_accept_top_qos <= 1'b0;
    end else begin
      queue_accept_top_qos <= accept && is_top_qos;
    end
  end

  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      clear_tracking <= 1'b0;
    end else begin
      clear_tracking <= clear_d;
    end
  end

endmodule : home_node_perf_event_gen

//--- perf_event_gen_sva.sv
`timescale 1ns/1ns
module perf_event_gen_sva #(
  parameter int unsigned CYCLE_W = 32,
  parameter int unsigned QOS_W   = 4
) (
  input wire logic                         clk,
  nrst,
  global_clock_running,
  cycle_count_reset,
  miss_rate_slot_granted,
  lookup_valid,
  lookup_high_priority,
  lookup_hit,
  fill_valid,
  req_valid,
  req_credit_available,
  snoop_valid,
  snoop_broadcast,
  requester_evict_valid,
  requester_line_shared,
  cluster_single_requester,
  slc_miss_event,
  slc_access_event,
  slc_fill_event,
  retry_ack,
  queue_retry_event,
  top_qos_retry_event,
  snoops_issued_event,
  snoop_broadcast_event,
  imprecise_evict_event,
  clear_tracking,
  input wire logic [CYCLE_W-1:0]           cycle_count,
  input wire logic [QOS_W-1:0]             req_qos,
  input wire perf_event_pkg::lookup_kind_t lookup_kind,
  input wire perf_event_pkg::fill_source_t fill_source
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (!nrst);
  // Four idle samples cover two synchroniser stages, the counter and the output register.
  a_cycle_hold: assert property ((!global_clock_running && !cycle_count_reset)[*4] |=>
    $stable(cycle_count)) else $error("cycle count moved while clock stopped");
  a_miss_first: assert property (slc_miss_event == $past(lookup_valid && !lookup_hit &&
    lookup_kind == perf_event_pkg::LOOKUP_FIRST && lookup_high_priority && miss_rate_slot_granted))
    else $error("miss pulse wrong");
  a_access_first: assert property (slc_access_event == $past(lookup_valid &&
    lookup_kind == perf_event_pkg::LOOKUP_FIRST && lookup_high_priority && miss_rate_slot_granted))
    else $error("access pulse wrong");
  a_fill_all: assert property (slc_fill_event ==
    $past(fill_valid && fill_source != perf_event_pkg::FILL_NONE)) else $error("fill pulse wrong");
  a_retry_ack: assert property (req_valid && !req_credit_available |=>
    retry_ack && queue_retry_event) else $error("retry missing");
  a_top_retry: assert property (top_qos_retry_event == $past(req_valid &&
    !req_credit_available && req_qos == perf_event_pkg::QOS_TOP)) else $error("top retry wrong");
  a_snoop_pair: assert property (snoop_valid |=> snoops_issued_event &&
    snoop_broadcast_event == $past(snoop_broadcast)) else $error("snoop pulses wrong");
  a_evict_keep: assert property (requester_evict_valid && requester_line_shared &&
    !cluster_single_requester |=> imprecise_evict_event && !clear_tracking)
    else $error("shared evict cleared tracking");
  a_evict_clear: assert property (requester_evict_valid && cluster_single_requester |=>
    clear_tracking) else $error("single evict kept tracking");
  c_retry: cover property (retry_ack);
  c_imprecise: cover property (imprecise_evict_event);
  c_fill: cover property (slc_fill_event);
endmodule : perf_event_gen_sva
bind home_node_perf_event_gen perf_event_gen_sva #(.CYCLE_W(CYCLE_W), .QOS_W(QOS_W)) u_sva (.*);

//--- perf_event_pkg.sv
package perf_event_pkg;

  localparam int unsigned CYCLE_WIDTH      = 32;
  localparam int unsigned MAX_MISS_RATE_HN = 4;
  localparam int unsigned CLUSTER_WIDTH    = 4;
  localparam int unsigned QOS_WIDTH        = 4;
  localparam logic [3:0]  QOS_TOP          = 4'hF;
  localparam logic [3:0]  QOS_HIGH_MIN     = 4'hC;
  localparam int unsigned SYNC_STAGES      = 2;

  typedef enum logic [1:0] {
    LOOKUP_FIRST  = 2'h0,
    LOOKUP_TAG    = 2'h1,
    LOOKUP_VICTIM = 2'h3,
    LOOKUP_FILL   = 2'h2
  } lookup_kind_t;

  typedef enum logic [2:0] {
    FILL_NONE       = 3'h0,
    FILL_UNIQUE     = 3'h1,
    FILL_WRITE_BACK = 3'h2,
    FILL_EVICTION   = 3'h3,
    FILL_OTHER      = 3'h4
  } fill_source_t;

endpackage : perf_event_pkg

//--- test_home_node_perf_event_gen.sv
`timescale 1ns/1ns
module test_home_node_perf_event_gen;
  logic clk = 1'b0, nrst = 1'b0, tally_clr, global_clock_running, cycle_count_reset;
  logic miss_rate_slot_granted, lookup_valid, lookup_high_priority, lookup_hit, fill_valid;
  logic req_valid, req_credit_available, req_static_credit, filter_lookup_valid;
  logic filter_lookup_hit, filter_evict_valid, filter_evict_shared, snoop_valid, snoop_broadcast;
  logic memctl_request, memctl_retry, requester_evict_valid, requester_line_shared;
  logic cluster_single_requester, retry_ack, awaiting_static_credit, queue_accept;
  logic queue_accept_top_qos, clear_tracking, slc_miss_event, slc_access_event, slc_fill_event;
  logic queue_retry_event, requests_received_event, filter_hit_event, filter_eviction_event;
  logic snoops_issued_event, snoop_broadcast_event, memctl_retry_event, memctl_request_event;
  logic cluster_snoop_event, imprecise_evict_event, shared_line_evict_event, top_qos_retry_event;
  logic [3:0]  req_qos, snoop_clusters;
  logic [31:0] cycle_count, v;
  logic [14:0] ev;
  logic [15:0] cnt [15];
  perf_event_pkg::lookup_kind_t lookup_kind, filter_lookup_kind;
  perf_event_pkg::fill_source_t fill_source;
  int err_total = 0, compares = 0;
  assign ev = {top_qos_retry_event, shared_line_evict_event, imprecise_evict_event,
    cluster_snoop_event, memctl_request_event, memctl_retry_event, snoop_broadcast_event,
    snoops_issued_event, filter_eviction_event, filter_hit_event, requests_received_event,
    queue_retry_event, slc_fill_event, slc_access_event, slc_miss_event};
  always #10 clk = ~clk;
  home_node_perf_event_gen u_home_node_perf_event_gen (.*);
  event_tally u_event_tally (.clk(clk), .nrst(nrst), .clr(tally_clr), .ev(ev), .cnt(cnt));
  task tick;
    @(negedge clk);
  endtask : tick
  task idle;
    {cycle_count_reset, lookup_valid, lookup_high_priority, lookup_hit, fill_valid, req_valid,
     req_credit_available, req_static_credit, filter_lookup_valid, filter_lookup_hit,
     filter_evict_valid, filter_evict_shared, snoop_valid, snoop_broadcast, memctl_request,
     memctl_retry, requester_evict_valid, requester_line_shared, cluster_single_requester} = '0;
    {global_clock_running, miss_rate_slot_granted} = 2'h3;
    {req_qos, snoop_clusters} = 8'h00;
    lookup_kind = perf_event_pkg::LOOKUP_FIRST;
    filter_lookup_kind = perf_event_pkg::LOOKUP_FIRST;
    fill_source = perf_event_pkg::FILL_NONE;
  endtask : idle
  // Clearing the tally before each event test (all but t_cycle) keeps expectations local to that test.
  task start;
    tally_clr = 1'b1;
    tick;
    tally_clr = 1'b0;
  endtask : start
  task settle;
    idle;
    repeat (3) tick;
  endtask : settle
  task chk(input logic [31:0] got, input logic [31:0] exp);
    compares++;
    if (got !== exp) begin
      err_total++;
      $display("[FAIL] %0t got %0h expected %0h", $time, got, exp);
    end
  endtask : chk
  task t_cache;
    start;
    {lookup_valid, lookup_high_priority, lookup_hit} = 3'h7;
    tick;
    lookup_hit = 1'b0;
    tick;
    for (int i = 1; i < 4; i++) begin
      lookup_kind = perf_event_pkg::lookup_kind_t'(i[1:0]);
      tick;
    end
    lookup_kind = perf_event_pkg::LOOKUP_FIRST;
    lookup_high_priority = 1'b0;
    tick;
    {lookup_high_priority, miss_rate_slot_granted} = 2'h2;
    tick;
    idle;
    fill_valid = 1'b1;
    for (int i = 0; i < 5; i++) begin
      fill_source = perf_event_pkg::fill_source_t'(i[2:0]);
      tick;
    end
    settle;
    chk(32'(cnt[1]), 32'h2);
    chk(32'(cnt[0]), 32'h1);
    chk(32'(cnt[2]), 32'h4);
    $display("cache test done");
  endtask : t_cache
  task t_req;
    start;
    {req_valid, req_qos} = 5'h1F;
    tick;
    chk(32'(retry_ack), 32'h1);
    chk(32'(top_qos_retry_event), 32'h1);
    req_qos = 4'h1;
    tick;
    {req_credit_available, req_qos} = 5'h1F;
    tick;
    chk(32'(queue_accept), 32'h1);
    chk(32'(queue_accept_top_qos), 32'h1);
    chk(32'(awaiting_static_credit), 32'h1);
    settle;
    chk(32'(cnt[3]), 32'h2);
    chk(32'(cnt[4]), 32'h3);
    chk(32'(cnt[14]), 32'h1);
    req_static_credit = 1'b1;
    tick;
    chk(32'(awaiting_static_credit), 32'h0);
    req_static_credit = 1'b0;
    $display("request test done");
  endtask : t_req
  task t_snoop;
    start;
    {filter_lookup_valid, filter_lookup_hit, filter_evict_valid, memctl_request} = 4'hF;
    for (int i = 0; i < 4; i++) begin
      filter_lookup_kind = perf_event_pkg::lookup_kind_t'(i[1:0]);
      filter_evict_shared = i[0];
      memctl_retry = (i == 0);
      snoop_valid = (i < 2);
      snoop_broadcast = (i == 0);
      snoop_clusters = (i == 0) ? 4'h4 : 4'h0;
      tick;
    end
    settle;
    chk(32'(cnt[5]), 32'h1);
    chk(32'(cnt[6]), 32'h4);
    chk(32'(cnt[13]), 32'h2);
    chk(32'(cnt[7]), 32'h2);
    chk(32'(cnt[8]), 32'h1);
    chk(32'(cnt[11]), 32'h1);
    chk(32'(cnt[9]), 32'h1);
    chk(32'(cnt[10]), 32'h4);
    $display("snoop test done");
  endtask : t_snoop
  task t_evict;
    start;
    {requester_evict_valid, requester_line_shared} = 2'h3;
    tick;
    chk(32'(clear_tracking), 32'h0);
    cluster_single_requester = 1'b1;
    tick;
    chk(32'(clear_tracking), 32'h1);
    settle;
    chk(32'(cnt[12]), 32'h1);
    $display("evict test done");
  endtask : t_evict
  // The counter runs first so that the hold and the clear both act on a non-zero count.
  task t_cycle;
    repeat (10) tick;
    v = cycle_count;
    repeat (20) tick;
    chk(cycle_count, v + 32'h14);
    global_clock_running = 1'b0;
    repeat (4) tick;
    v = cycle_count;
    repeat (5) tick;
    chk(cycle_count, v);
    cycle_count_reset = 1'b1;
    tick;
    cycle_count_reset = 1'b0;
    repeat (3) tick;
    chk(cycle_count, 32'h0);
    $display("cycle test done");
  endtask : t_cycle
  task final_report;
    $display("compares %0d mismatches %0d", compares, err_total);
    if (err_total == 0 && compares > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask : final_report
  initial begin
    idle;
    tally_clr = 1'b0;
    repeat (2) tick;
    nrst = 1'b1;
    t_cache;
    t_req;
    t_snoop;
    t_evict;
    nrst = 1'b0;
    tick;
    nrst = 1'b1;
    t_cycle;
    final_report;
  end
  initial begin
    repeat (5000) @(posedge clk);
    err_total++;
    final_report;
  end
endmodule : test_home_node_perf_event_gen
